// *** sram_key_pkg.sv ***
// Shared types and constants for the secure SRAM key buffer store
package sram_key_pkg;

   // ****************************************
   // Buffer sizes
   // ****************************************
   localparam int HALF_W = 256; // One 32-byte half
   localparam int FULL_W = 512; // 64 bytes
   localparam int HCTX_W = 320; // Hash state plus length count
   localparam int SLOT_W = 4; // Data-zone slot index width
   localparam int GEN_W = 4; // Digest-generated field width

   // ****************************************
   // APB register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00; // Control
   localparam logic [7:0] ADDR_SK_FLAGS = 8'h04; // Scratch key flags
   localparam logic [7:0] ADDR_BUF_STAT = 8'h08; // Buffer status
   localparam logic [7:0] ADDR_ERR_CNT = 8'h0c; // Error counter

   // Control fields
   localparam int CTRL_WIPE = 0; // Self-clearing wipe request
   localparam int CTRL_HOLD = 1; // Refuse engine key, digest and alternate key writes; hash context ops still served
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   // Scratch key flag field positions
   localparam int FL_VLO = 0;
   localparam int FL_VHI = 1;
   localparam int FL_SLOT = 2;
   localparam int FL_FIXED = 6;
   localparam int FL_GEN = 7;
   localparam int FL_KEY_GENERATE_CMD = 11;
   localparam int FL_NOMAC = 12;

   // Buffer status positions
   localparam int BS_MD = 0;
   localparam int BS_AK = 1;
   localparam int BS_HC = 2;

   // ****************************************
   // Command kinds of the execution engine
   // ****************************************
   typedef enum logic [3:0] {
      CMD_NONE, CMD_NONCE, CMD_KDF, CMD_DIGEST_GENERATE_CMD, CMD_KEY_GENERATE_CMD, CMD_MAC,
      CMD_VERIFY, CMD_SIGN, CMD_SHA, CMD_AES, CMD_OTHER
   } cmd_type;

   typedef enum logic [1:0] {HC_INIT, HC_UPDATE, HC_FINAL} hc_op_type;

   // ****************************************
   // Engine request and answer carriers
   // ****************************************
   typedef struct packed {
      logic en; // Write strobe
      logic lo; // Write lower half
      logic hi; // Write upper half
      cmd_type cmd; // Writing command
      logic [FULL_W-1:0] data; // Hi in upper bits
      logic [SLOT_W-1:0] slot; // Slot used
      logic fixed_src; // Fixed input, no random
      logic by_digest_generate_cmd; // Made by digest generation
      logic by_key_generate_cmd; // Made by key generation
      logic mac_inh; // Some slot inhibits MAC
   } sk_wr_type;

   typedef struct packed {
      logic en;
      cmd_type cmd;
   } rd_req_type;

   typedef struct packed {
      logic en;
      logic len64; // Nonce writes 64 rather than 32 bytes
      cmd_type cmd;
      logic [FULL_W-1:0] data;
   } md_wr_type;

   typedef struct packed {
      logic en;
      cmd_type cmd;
      logic src_scratch; // Verify digest comes from scratch key
   } md_rd_type;

   typedef struct packed {
      logic en;
      cmd_type cmd;
      logic [HALF_W-1:0] data;
   } ak_wr_type;

   typedef struct packed {
      logic en;
      cmd_type cmd;
      hc_op_type op;
      logic [HCTX_W-1:0] data;
   } hc_req_type;

   typedef struct packed {
      logic sleep;
      logic brownout;
      logic watchdog;
      logic tamper;
   } wipe_type;

   typedef struct packed {
      logic ok; // Request served
      logic err; // Request refused
   } rsp_type;

endpackage

// *** secure_sram_key_buffers.sv ***
// Volatile key, digest, alternate key and hash context store
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module secure_sram_key_buffers
   import sram_key_pkg::*;
(
   input wire logic i_clock, // 200 MHz clock
   input wire logic i_sys_rst, // Async reset, power-up
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB direction
   input wire logic [7:0] i_paddr, // APB byte address
   input wire logic [31:0] i_pwdata, // APB write data
   output logic o_pready, // APB ready
   output logic [31:0] o_prdata, // APB read data
   output logic o_pslverr, // APB error
   input wire sram_key_pkg::wipe_type i_wipe, // Clearing events
   input wire sram_key_pkg::sk_wr_type i_sk_wr, // Key write
   input wire sram_key_pkg::rd_req_type i_sk_rd, // Key use
   input wire sram_key_pkg::md_wr_type i_md_wr, // Digest write
   input wire sram_key_pkg::md_rd_type i_md_rd, // Digest use
   input wire sram_key_pkg::ak_wr_type i_ak_wr, // Alt key write
   input wire sram_key_pkg::rd_req_type i_ak_rd, // Alt key use
   input wire sram_key_pkg::hc_req_type i_hc, // Hash context op
   input wire logic i_cmd_done, // Command finished pulse
   input wire sram_key_pkg::cmd_type i_done_cmd, // Finished command
   output logic [FULL_W-1:0] o_sk_data, // Key to engine
   output sram_key_pkg::rsp_type o_sk_rsp, // Key use answer
   output sram_key_pkg::rsp_type o_wr_rsp, // Key write answer
   output logic [FULL_W-1:0] o_md_data, // Digest to engine
   output logic [HALF_W-1:0] o_nonce, // Verify nonce
   output sram_key_pkg::rsp_type o_md_rsp, // Digest use answer
   output logic [HALF_W-1:0] o_ak_data, // Alt key to engine
   output sram_key_pkg::rsp_type o_ak_rsp, // Alt key answer
   output logic [HCTX_W-1:0] o_hc_data, // Hash context out
   output sram_key_pkg::rsp_type o_hc_rsp // Hash context answer
);
   import sram_key_pkg::*;

   // ****************************************
   // Helper functions
   // ****************************************
   // Commands allowed to write the upper key half
   function automatic logic may_write_hi(input cmd_type c);
      may_write_hi = (c == CMD_KDF) || (c == CMD_NONCE);
   endfunction

   // Commands whose use leaves the key and flags intact
   function automatic logic keeps_key(input cmd_type c);
      keeps_key = (c == CMD_KDF) || (c == CMD_AES);
   endfunction

   // Commands after which the digest buffer survives
   function automatic logic keeps_md(input cmd_type c);
      keeps_md = (c == CMD_NONCE) || (c == CMD_SHA);
   endfunction

   // ****************************************
   // Storage
   // ****************************************
   logic [FULL_W-1:0] sk_q; // Scratch key data
   logic vlo_q; // Lower half valid
   logic vhi_q; // Upper half valid
   logic [SLOT_W-1:0] slot_q; // Source slot index
   logic fixed_q; // Randomness source flag
   logic [GEN_W-1:0] gen_q; // Digest generated field
   logic key_generate_cmd_q; // Key generated flag
   logic nomac_q; // MAC forbidden flag
   logic [FULL_W-1:0] md_q; // Message digest buffer
   logic md_v_q; // Digest loaded
   logic [HALF_W-1:0] ak_q; // Alternate key store
   logic ak_v_q; // Alternate key loaded
   logic [HCTX_W-1:0] hc_q; // Hash context
   logic hc_v_q; // Hash sequence open
   logic [31:0] ctrl_q; // Control register
   logic [31:0] err_cnt_q; // Refusal counter

   // ****************************************
   // Combinational decisions
   // ****************************************
   logic wipe; // Any clearing event
   logic hold; // Key, digest and alt key writes refused
   logic sk_wr_ok; // Key write accepted
   logic sk_rd_ok; // Key use accepted
   logic sk_rd_clr; // Key flags clear on this use
   logic md_rd_ok; // Digest use accepted
   logic hc_ok; // Hash context op accepted
   logic any_err; // Some request refused
   logic apb_setup; // APB setup cycle
   logic apb_access; // APB completing cycle

   // Wipe covers sleep, brown-out, watchdog, tamper and software
   assign wipe = i_wipe.sleep | i_wipe.brownout | i_wipe.watchdog |
      i_wipe.tamper | ctrl_q[CTRL_WIPE];
   assign hold = ctrl_q[CTRL_HOLD];

   // Upper half needs a privileged writer and a valid lower half
   assign sk_wr_ok = i_sk_wr.en && !hold && (i_sk_wr.lo || i_sk_wr.hi) &&
      (!i_sk_wr.hi || may_write_hi(i_sk_wr.cmd)) &&
      (!i_sk_wr.hi || i_sk_wr.lo || vlo_q);

   // Invalid content refused; MAC-inhibited content refused for MAC use only
   assign sk_rd_ok = i_sk_rd.en && vlo_q &&
      !(i_sk_rd.cmd == CMD_MAC && nomac_q);

   // Any use, served or failed, clears unless cipher or derivation
   assign sk_rd_clr = i_sk_rd.en && !keeps_key(i_sk_rd.cmd);

   assign md_rd_ok = i_md_rd.en && md_v_q;
   // Only the hash command reaches the context
   assign hc_ok = i_hc.en && (i_hc.cmd == CMD_SHA) &&
      (i_hc.op == HC_INIT || hc_v_q);

   assign any_err = (i_sk_wr.en && !sk_wr_ok) ||
      (i_sk_rd.en && !sk_rd_ok) || (i_md_rd.en && !md_rd_ok) ||
      (i_ak_rd.en && !ak_v_q) || (i_hc.en && !hc_ok);

   assign apb_setup = i_psel && !i_penable;
   assign apb_access = i_psel && i_penable && o_pready;

   // ****************************************
   // Scratch key data
   // ****************************************
   // Data is only wiped, never cleared by use; use needs a valid lower half, upper half sent as stored
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sk_q <= '0;
      end else if (wipe) begin
         sk_q <= '0;
      end else if (sk_wr_ok) begin
         if (i_sk_wr.lo) begin
            sk_q[HALF_W-1:0] <= i_sk_wr.data[HALF_W-1:0];
         end
         if (i_sk_wr.hi) begin
            sk_q[FULL_W-1:HALF_W] <= i_sk_wr.data[FULL_W-1:HALF_W];
         end
      end
   end

   // ****************************************
   // Scratch key flags
   // ****************************************
   // Idle mode has no input here, so it leaves all state alone
   // A write in the same cycle as a clearing use wins over the clear
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         vlo_q <= 1'b0;
         vhi_q <= 1'b0;
         slot_q <= '0;
         fixed_q <= 1'b0;
         gen_q <= '0;
         key_generate_cmd_q <= 1'b0;
         nomac_q <= 1'b0;
      end else if (wipe) begin
         vlo_q <= 1'b0;
         vhi_q <= 1'b0;
         slot_q <= '0;
         fixed_q <= 1'b0;
         gen_q <= '0;
         key_generate_cmd_q <= 1'b0;
         nomac_q <= 1'b0;
      end else if (sk_wr_ok) begin
         vlo_q <= 1'b1;
         // Lower-only rewrite stales the upper half
         vhi_q <= i_sk_wr.hi || (vhi_q && !i_sk_wr.lo);
         fixed_q <= i_sk_wr.fixed_src;
         gen_q <= {{(GEN_W-1){1'b0}}, i_sk_wr.by_digest_generate_cmd};
         key_generate_cmd_q <= i_sk_wr.by_key_generate_cmd;
         nomac_q <= i_sk_wr.mac_inh;
         // Slot only meaningful for generated content
         if (i_sk_wr.by_digest_generate_cmd || i_sk_wr.by_key_generate_cmd) begin
            slot_q <= i_sk_wr.slot;
         end else begin
            slot_q <= '0;
         end
      end else if (sk_rd_clr) begin
         vlo_q <= 1'b0;
         vhi_q <= 1'b0;
         slot_q <= '0;
         fixed_q <= 1'b0;
         gen_q <= '0;
         key_generate_cmd_q <= 1'b0;
         nomac_q <= 1'b0;
      end
   end

   // ****************************************
   // Message digest buffer
   // ****************************************
   // Use and most command completions empty it; a write wins
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         md_q <= '0;
         md_v_q <= 1'b0;
      end else if (wipe) begin
         md_q <= '0;
         md_v_q <= 1'b0;
      end else if (i_md_wr.en && !hold &&
         (i_md_wr.cmd == CMD_SHA || i_md_wr.cmd == CMD_NONCE)) begin
         md_v_q <= 1'b1;
         if (i_md_wr.cmd == CMD_NONCE && !i_md_wr.len64) begin
            md_q <= {{HALF_W{1'b0}}, i_md_wr.data[HALF_W-1:0]};
         end else begin
            md_q <= i_md_wr.data;
         end
      end else if (i_md_rd.en ||
         (i_cmd_done && !keeps_md(i_done_cmd))) begin
         md_q <= '0;
         md_v_q <= 1'b0;
      end
   end

   // ****************************************
   // Alternate key store
   // ****************************************
   // Fixed data from nonce, secret data from key derivation
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ak_q <= '0;
         ak_v_q <= 1'b0;
      end else if (wipe) begin
         ak_q <= '0;
         ak_v_q <= 1'b0;
      end else if (i_ak_wr.en && !hold &&
         (i_ak_wr.cmd == CMD_NONCE || i_ak_wr.cmd == CMD_KDF)) begin
         ak_q <= i_ak_wr.data;
         ak_v_q <= 1'b1;
      end
   end

   // ****************************************
   // Hash context
   // ****************************************
   // Other commands never disturb it, failed or not
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hc_q <= '0;
         hc_v_q <= 1'b0;
      end else if (wipe) begin
         hc_q <= '0;
         hc_v_q <= 1'b0;
      end else if (hc_ok) begin
         case (i_hc.op)
            HC_INIT: begin
               hc_q <= i_hc.data;
               hc_v_q <= 1'b1;
            end
            HC_UPDATE: begin
               hc_q <= i_hc.data;
            end
            HC_FINAL: begin
               hc_q <= '0;
               hc_v_q <= 1'b0;
            end
            default: begin
               hc_v_q <= hc_v_q;
            end
         endcase
      end
   end

   // ****************************************
   // Engine answers, one cycle after request
   // ****************************************
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_sk_data <= '0;
         o_sk_rsp <= '0;
         o_wr_rsp <= '0;
      end else begin
         // Zero data unless served, so nothing leaks on refusal
         o_sk_data <= sk_rd_ok ? sk_q : '0;
         o_sk_rsp <= '{ok: sk_rd_ok, err: i_sk_rd.en && !sk_rd_ok};
         o_wr_rsp <= '{ok: sk_wr_ok, err: i_sk_wr.en && !sk_wr_ok};
      end
   end

   // Digest, alternate key and context answers
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_md_data <= '0;
         o_nonce <= '0;
         o_md_rsp <= '0;
         o_ak_data <= '0;
         o_ak_rsp <= '0;
         o_hc_data <= '0;
         o_hc_rsp <= '0;
      end else begin
         o_md_data <= md_rd_ok ? md_q : '0;
         // Digest in scratch key: nonce low; digest here: nonce high
         if (!md_rd_ok) begin
            o_nonce <= '0;
         end else if (i_md_rd.src_scratch) begin
            o_nonce <= md_q[HALF_W-1:0];
         end else begin
            o_nonce <= md_q[FULL_W-1:HALF_W];
         end
         o_md_rsp <= '{ok: md_rd_ok, err: i_md_rd.en && !md_rd_ok};
         o_ak_data <= (i_ak_rd.en && ak_v_q) ? ak_q : '0;
         o_ak_rsp <= '{ok: i_ak_rd.en && ak_v_q,
            err: i_ak_rd.en && !ak_v_q};
         o_hc_data <= (hc_ok && i_hc.op == HC_FINAL) ? hc_q : '0;
         o_hc_rsp <= '{ok: hc_ok, err: i_hc.en && !hc_ok};
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   // No wait state: ready rises in the cycle after setup
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= apb_setup;
      end
   end

   // Read data and error captured in setup; key data never mapped
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_prdata <= '0;
         o_pslverr <= 1'b0;
      end else if (apb_setup) begin
         o_pslverr <= 1'b0;
         o_prdata <= '0;
         case (i_paddr)
            ADDR_CTRL: begin
               o_prdata <= ctrl_q;
            end
            ADDR_SK_FLAGS: begin
               o_prdata[FL_VLO] <= vlo_q;
               o_prdata[FL_VHI] <= vhi_q;
               o_prdata[FL_SLOT +: SLOT_W] <= slot_q;
               o_prdata[FL_FIXED] <= fixed_q;
               o_prdata[FL_GEN +: GEN_W] <= gen_q;
               o_prdata[FL_KEY_GENERATE_CMD] <= key_generate_cmd_q;
               o_prdata[FL_NOMAC] <= nomac_q;
            end
            ADDR_BUF_STAT: begin
               o_prdata[BS_MD] <= md_v_q;
               o_prdata[BS_AK] <= ak_v_q;
               o_prdata[BS_HC] <= hc_v_q;
            end
            ADDR_ERR_CNT: begin
               o_prdata <= err_cnt_q;
            end
            default: begin
               o_pslverr <= 1'b1; // Unmapped address
            end
         endcase
      end
   end

   // Control: wipe bit clears itself after one cycle
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_q <= CTRL_RST;
      end else if (apb_access && i_pwrite && i_paddr == ADDR_CTRL) begin
         ctrl_q <= {30'h0000_0000, i_pwdata[CTRL_HOLD],
            i_pwdata[CTRL_WIPE]};
      end else begin
         ctrl_q[CTRL_WIPE] <= 1'b0;
      end
   end

   // Refusal counter; a software clear with a new refusal in the same cycle leaves 1
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         err_cnt_q <= '0;
      end else if (any_err) begin
         if (apb_access && i_pwrite && i_paddr == ADDR_ERR_CNT) begin
            err_cnt_q <= 32'h0000_0001;
         end else begin
            err_cnt_q <= err_cnt_q + 32'h0000_0001;
         end
      end else if (apb_access && i_pwrite && i_paddr == ADDR_ERR_CNT) begin
         err_cnt_q <= '0;
      end
   end

endmodule

// *** secure_sram_key_buffers_props.sv ***
// Checker for the secure SRAM key buffer store ports
`timescale 1ns/1ps
module secure_sram_key_buffers_props
   import sram_key_pkg::*;
(
   input wire logic i_clock, // Clock
   input wire logic i_sys_rst, // Async reset
   input wire sram_key_pkg::wipe_type i_wipe, // Clear events
   input wire sram_key_pkg::sk_wr_type i_sk_wr, // Key write
   input wire sram_key_pkg::rd_req_type i_sk_rd, // Key use
   input wire logic [FULL_W-1:0] o_sk_data, // Key out
   input wire sram_key_pkg::rsp_type o_sk_rsp, // Key answer
   input wire sram_key_pkg::rsp_type o_wr_rsp, // Write answer
   input wire sram_key_pkg::md_wr_type i_md_wr, // Digest write
   input wire sram_key_pkg::md_rd_type i_md_rd, // Digest use
   input wire logic [FULL_W-1:0] o_md_data, // Digest out
   input wire logic [HALF_W-1:0] o_nonce, // Verify nonce
   input wire sram_key_pkg::rsp_type o_md_rsp, // Digest answer
   input wire sram_key_pkg::hc_req_type i_hc, // Hash op
   input wire sram_key_pkg::rsp_type o_hc_rsp // Hash answer
);
   // ****************************************
   // Properties, one clock domain
   // ****************************************
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   chk_upper_perm: assert property (
      i_sk_wr.en && i_sk_wr.hi && !(i_sk_wr.cmd inside {CMD_KDF, CMD_NONCE})
      |=> o_wr_rsp.err) else $error("upper half write not refused");
   chk_key_hidden: assert property (
      o_sk_data != '0 |-> o_sk_rsp.ok && $past(i_sk_rd.en))
      else $error("key data shown without a served use");
   chk_use_answer: assert property (
      i_sk_rd.en |=> o_sk_rsp.ok != o_sk_rsp.err)
      else $error("key use not answered once");
   chk_refused_blank: assert property (
      o_sk_rsp.err |-> o_sk_data == '0) else $error("refused use gave data");
   // Wipe with no write beside it leaves nothing to use
   chk_wipe_clears: assert property (
      ((|i_wipe) && !i_sk_wr.en) ##1 (i_sk_rd.en && !i_sk_wr.en)
      |=> o_sk_rsp.err) else $error("key usable after wipe");
   chk_digest_once: assert property (
      (i_md_rd.en && !i_md_wr.en) ##1 !i_md_wr.en ##1
      (i_md_rd.en && !i_md_wr.en) |=> o_md_rsp.err)
      else $error("digest used twice per load");
   chk_nonce_src: assert property (
      (i_md_rd.en && i_md_rd.cmd == CMD_VERIFY) ##1 o_md_rsp.ok
      |-> o_nonce == ($past(i_md_rd.src_scratch) ? o_md_data[HALF_W-1:0]
      : o_md_data[FULL_W-1:HALF_W])) else $error("verify nonce misplaced");
   chk_hash_owner: assert property (
      i_hc.en && i_hc.cmd != CMD_SHA |=> o_hc_rsp.err)
      else $error("hash context served a foreign command");
   cover property (i_sk_rd.en ##1 o_sk_rsp.ok);
   cover property (i_md_rd.en ##1 o_md_rsp.err);
   cover property (i_hc.en ##1 o_hc_rsp.ok);
endmodule
bind secure_sram_key_buffers secure_sram_key_buffers_props chk_u (
   .i_clock, .i_sys_rst, .i_wipe, .i_sk_wr, .i_sk_rd, .o_sk_data,
   .o_sk_rsp, .o_wr_rsp, .i_md_wr, .i_md_rd, .o_md_data, .o_nonce,
   .o_md_rsp, .i_hc, .o_hc_rsp);

// *** cmd_engine_model.sv ***
// Command execution engine model issuing buffer requests
`timescale 1ns/1ps
module cmd_engine_model
   import sram_key_pkg::*;
(
   input wire logic i_clock, // Device clock
   output sram_key_pkg::sk_wr_type o_sk_wr, // Key write
   output sram_key_pkg::rd_req_type o_sk_rd, // Key use
   output sram_key_pkg::md_wr_type o_md_wr, // Digest write
   output sram_key_pkg::md_rd_type o_md_rd, // Digest use
   output sram_key_pkg::ak_wr_type o_ak_wr, // Alt key write
   output sram_key_pkg::rd_req_type o_ak_rd, // Alt key use
   output sram_key_pkg::hc_req_type o_hc, // Hash op
   output logic o_done, // Command finished
   output sram_key_pkg::cmd_type o_done_cmd // Finished command
);
   // Idle engine: no strobes at time zero
   initial begin
      {o_sk_wr, o_sk_rd, o_md_wr, o_md_rd, o_ak_wr, o_ak_rd, o_hc} = '0;
      o_done = 1'b0;
      o_done_cmd = CMD_NONE;
   end
   // One-cycle strobe, then all lines but the finished command back to zero, answer settled
   task automatic go(input sk_wr_type w = '0, input rd_req_type kr = '0,
         input md_wr_type mw = '0, input md_rd_type mr = '0,
         input ak_wr_type aw = '0, input rd_req_type ar = '0,
         input hc_req_type h = '0, input cmd_type dc = CMD_NONE);
      @(posedge i_clock);
      {o_sk_wr, o_sk_rd, o_md_wr, o_md_rd, o_ak_wr, o_ak_rd, o_hc} <=
         {w, kr, mw, mr, aw, ar, h};
      o_done <= (dc != CMD_NONE);
      o_done_cmd <= dc;
      @(posedge i_clock);
      {o_sk_wr, o_sk_rd, o_md_wr, o_md_rd, o_ak_wr, o_ak_rd, o_hc} <= '0;
      o_done <= 1'b0;
      #1;
   endtask
endmodule

// *** tb.sv ***
// Self-checking testbench for the secure SRAM key buffer store
`timescale 1ns/1ps
module tb;
   import sram_key_pkg::*;
   // Distinct halves so a swapped half shows up
   localparam logic [FULL_W-1:0] KD = {{8{32'ha5a5_0f0f}},
      {8{32'h1234_5678}}};
   localparam logic [HALF_W-1:0] KH = KD[FULL_W-1:HALF_W];
   logic i_clock = 1'b0, i_sys_rst = 1'b1, i_pwrite = 1'b0;
   logic i_psel = 1'b0, i_penable = 1'b0, o_pready, o_pslverr, e;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, o_prdata, q;
   wipe_type i_wipe = '0;
   sk_wr_type i_sk_wr;
   rd_req_type i_sk_rd, i_ak_rd;
   md_wr_type i_md_wr;
   md_rd_type i_md_rd;
   ak_wr_type i_ak_wr;
   hc_req_type i_hc;
   logic i_cmd_done;
   cmd_type i_done_cmd;
   logic [FULL_W-1:0] o_sk_data, o_md_data;
   logic [HALF_W-1:0] o_nonce, o_ak_data;
   logic [HCTX_W-1:0] o_hc_data;
   rsp_type o_sk_rsp, o_wr_rsp, o_md_rsp, o_ak_rsp, o_hc_rsp;
   int num_errors = 0;
   int n_tests = 0;
   always #2.5 i_clock = ~i_clock;
   cmd_engine_model eng_u (.i_clock, .o_sk_wr(i_sk_wr), .o_sk_rd(i_sk_rd),
      .o_md_wr(i_md_wr), .o_md_rd(i_md_rd), .o_ak_wr(i_ak_wr),
      .o_ak_rd(i_ak_rd), .o_hc(i_hc), .o_done(i_cmd_done),
      .o_done_cmd(i_done_cmd));
   secure_sram_key_buffers dut_u (.*);
   // ****************************************
   // Shared helpers
   // ****************************************
   task automatic print_verdict;
      $display("Mismatches %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok);
      n_tests++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t ns check failed", $realtime);
      end
   endtask
   // One APB transfer; held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (o_pready !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t ns no ready answer", $realtime);
         print_verdict;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q === x && e === 1'b0);
   endtask
   task automatic kw(input sk_wr_type w, input logic ok);
      eng_u.go(.w(w));
      chk(o_wr_rsp === {ok, ~ok});
   endtask
   task automatic ku(input cmd_type c, input logic ok);
      eng_u.go(.kr('{1'b1, c}));
      chk(o_sk_rsp === {ok, ~ok});
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic s_regs;
      rd(ADDR_CTRL, CTRL_RST);
      rd(ADDR_SK_FLAGS, 32'h0);
      rd(ADDR_BUF_STAT, 32'h0);
      apb(1'b1, ADDR_SK_FLAGS, 32'hffff_ffff);
      rd(ADDR_SK_FLAGS, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk(e === 1'b1 && q === 32'h0);
   endtask
   // Halves, flags, clear on use, refusals
   task automatic s_key;
      kw('{1, 1, 0, CMD_DIGEST_GENERATE_CMD, KD, 4'h5, 1, 1, 0, 0}, 1'b1);
      rd(ADDR_SK_FLAGS, 32'h0000_00d5);
      kw('{1, 0, 1, CMD_MAC, KD, 4'h0, 0, 0, 0, 0}, 1'b0);
      kw('{1, 0, 1, CMD_KDF, KD, 4'h0, 0, 0, 0, 0}, 1'b1);
      ku(CMD_KDF, 1'b1);
      chk(o_sk_data === KD);
      ku(CMD_AES, 1'b1);
      ku(CMD_MAC, 1'b1);
      rd(ADDR_SK_FLAGS, 32'h0);
      ku(CMD_SIGN, 1'b0);
      kw('{1, 0, 1, CMD_NONCE, KD, 4'h0, 0, 0, 0, 0}, 1'b0);
      kw('{1, 1, 0, CMD_KEY_GENERATE_CMD, KD, 4'h3, 0, 0, 1, 1}, 1'b1);
      rd(ADDR_SK_FLAGS, 32'h0000_180d);
      ku(CMD_MAC, 1'b0);
      rd(ADDR_SK_FLAGS, 32'h0);
   endtask
   // Each hardware clearing event wipes every buffer
   task automatic s_wipe;
      for (int i = 0; i < 4; i++) begin
         kw('{1, 1, 1, CMD_NONCE, KD, 4'h0, 1, 0, 0, 0}, 1'b1);
         eng_u.go(.mw('{1'b1, 1'b1, CMD_NONCE, KD}));
         eng_u.go(.aw('{1'b1, CMD_KDF, KH}));
         eng_u.go(.h('{1'b1, CMD_SHA, HC_INIT, '0}));
         rd(ADDR_BUF_STAT, 32'h7);
         i_wipe <= wipe_type'(4'h1 << i);
         ku(CMD_MAC, 1'b0);
         @(posedge i_clock);
         i_wipe <= '0;
         rd(ADDR_SK_FLAGS, 32'h0);
         rd(ADDR_BUF_STAT, 32'h0);
      end
   endtask
   task automatic s_md;
      eng_u.go(.mw('{1'b1, 1'b1, CMD_NONCE, KD}));
      eng_u.go(.mr('{1'b1, CMD_VERIFY, 1'b1}));
      chk(o_md_rsp.ok === 1'b1 && o_md_data === KD);
      chk(o_nonce === KD[HALF_W-1:0]);
      eng_u.go(.mr('{1'b1, CMD_SIGN, 1'b0}));
      chk(o_md_rsp.err === 1'b1);
      eng_u.go(.mw('{1'b1, 1'b0, CMD_NONCE, KD}));
      eng_u.go(.mr('{1'b1, CMD_VERIFY, 1'b0}));
      chk(o_md_data === {{HALF_W{1'b0}}, KD[HALF_W-1:0]});
      chk(o_nonce === '0);
      eng_u.go(.mw('{1'b1, 1'b1, CMD_SHA, KD}));
      eng_u.go(.dc(CMD_NONCE));
      rd(ADDR_BUF_STAT, 32'h1);
      eng_u.go(.dc(CMD_MAC));
      rd(ADDR_BUF_STAT, 32'h0);
   endtask
   // Alternate key writers, then the hash phases
   task automatic s_ak_hc;
      eng_u.go(.aw('{1'b1, CMD_MAC, KH}));
      rd(ADDR_BUF_STAT, 32'h0);
      eng_u.go(.aw('{1'b1, CMD_NONCE, KH}));
      eng_u.go(.ar('{1'b1, CMD_KDF}));
      chk(o_ak_rsp.ok === 1'b1 && o_ak_data === KH);
      eng_u.go(.h('{1'b1, CMD_SHA, HC_UPDATE, '0}));
      chk(o_hc_rsp.err === 1'b1);
      eng_u.go(.h('{1'b1, CMD_MAC, HC_INIT, '0}));
      chk(o_hc_rsp.err === 1'b1);
      eng_u.go(.h('{1'b1, CMD_SHA, HC_INIT, '0}));
      for (int i = 0; i < 3; i++) begin
         eng_u.go(.h('{1'b1, CMD_SHA, HC_UPDATE, HCTX_W'(i)}));
         chk(o_hc_rsp.ok === 1'b1);
      end
      ku(CMD_MAC, 1'b0);
      rd(ADDR_BUF_STAT, 32'h6);
      eng_u.go(.h('{1'b1, CMD_SHA, HC_FINAL, '0}));
      chk(o_hc_rsp.ok === 1'b1);
      chk(o_hc_data === HCTX_W'(2));
      // Hold refuses engine key writes; software wipe empties all buffers
      apb(1'b1, ADDR_CTRL, 32'h2);
      kw('{1, 1, 0, CMD_NONCE, KD, 4'h0, 1, 0, 0, 0}, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      rd(ADDR_BUF_STAT, 32'h0);
      apb(1'b1, ADDR_ERR_CNT, 32'h0);
      rd(ADDR_ERR_CNT, 32'h0);
      ku(CMD_SIGN, 1'b0);
      rd(ADDR_ERR_CNT, 32'h1);
   endtask
   // Main sequence: reset, scenarios, verdict
   initial begin
      repeat (20) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      s_regs;
      s_key;
      s_wipe;
      s_md;
      s_ak_hc;
      print_verdict;
   end
endmodule
